// File: verilog/lpm_pkg.sv
package lpm_pkg;
  // ==========================================================
  // mode codes presented by the core
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_RUN = 3'h0;
  localparam logic [2:0] MODE_SL0 = 3'h1;
  localparam logic [2:0] MODE_SL1 = 3'h2;
  localparam logic [2:0] MODE_SL2 = 3'h3;
  localparam logic [2:0] MODE_SL3 = 3'h4;
  localparam logic [2:0] MODE_SL4 = 3'h5;
  // ==========================================================
  // reset vector check
  localparam int VEC_W = 16;
  localparam logic [15:0] VEC_BLANK = 16'hFFFF;
  // ==========================================================
  // one-hot operating states
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_SL0 = 6'h02,
    ST_SL1 = 6'h04,
    ST_SL2 = 6'h08,
    ST_SL3 = 6'h10,
    ST_SL4 = 6'h20
  } op_state_t;
endpackage

// File: verilog/sync2.sv
`timescale 1ns/1ps
// ==========================================================
// two-stage synchroniser for pin-level inputs
module sync2 (
  input wire logic clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= 1'h0;
      q <= 1'h0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// File: verilog/low_power_mode_clock_gating.sv
`timescale 1ns/1ps
// Overview of operation
// - One full run mode and five sleep levels exist, picked by the core's mode code except on an interrupt wake or a blank part's forced level 4.
// - An interrupt wakes any sleep level except a blank part's level 4, and the prior level returns when the handler ends.
// - In full run mode main, sub-main and auxiliary clocks run and the core is enabled.
// - Sleep level 0 halts the core and main clock, keeping auxiliary and sub-main clocks.
// - Sleep level 1 is level 0 plus the dc generator off when the osc is not the run source.
// - Sleep level 2 halts core, main and sub-main clocks, keeps dc generator and aux clock.
// - Sleep level 3 halts core, main and sub-main clocks and dc generator, aux clock runs.
// - Sleep level 4 stops every clock, the dc generator and the crystal oscillator.
// - After power-up a blank all-ones reset vector sends the device straight to level 4.
module low_power_mode_clock_gating (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] mode_req,
  input wire logic irq_pending,
  input wire logic [15:0] reset_vector,
  input wire logic reset_vector_valid,
  input wire logic digitally_controlled_osc_in_run,
  output logic cpu_enable,
  output logic main_clk_en,
  output logic sub_main_clock_en,
  output logic aux_clk_en,
  output logic dc_gen_en,
  output logic xtal_osc_en,
  output logic wake_pulse,
  output logic [2:0] mode_state
);
  lpm_pkg::op_state_t state;
  lpm_pkg::op_state_t next_state;
  logic irq_sync;
  logic blank_checked;
  logic blank_hold;

  // ==========================================================
  // interrupt pin crossing; the core's mode code is same-domain
  sync2 irq_sync_inst (
    .clk(clk),
    .srst(srst),
    .d(irq_pending),
    .q(irq_sync)
  );

  // ==========================================================
  // blank reset vector check, caught once after release
  always_ff @(posedge clk) begin
    if (srst) begin
      blank_checked <= 1'h0;
    end else if (reset_vector_valid) begin
      blank_checked <= 1'h1;
    end
  end

  // ==========================================================
  // blank flag, sticky until reset since a blank part has no code
  always_ff @(posedge clk) begin
    if (srst) begin
      blank_hold <= 1'h0;
    end else if (!blank_checked && reset_vector_valid) begin
      blank_hold <= (reset_vector == lpm_pkg::VEC_BLANK);
    end
  end

  // ==========================================================
  // mode decode
  always_comb begin
    case (mode_req)
      lpm_pkg::MODE_SL0: next_state = lpm_pkg::ST_SL0;
      lpm_pkg::MODE_SL1: next_state = lpm_pkg::ST_SL1;
      lpm_pkg::MODE_SL2: next_state = lpm_pkg::ST_SL2;
      lpm_pkg::MODE_SL3: next_state = lpm_pkg::ST_SL3;
      lpm_pkg::MODE_SL4: next_state = lpm_pkg::ST_SL4;
      default: next_state = lpm_pkg::ST_RUN;
    endcase
    // wake overrides; the core drops its code while servicing, so the
    // saved level returns by itself when it restores the code
    if (irq_sync) begin
      next_state = lpm_pkg::ST_RUN;
    end
    // blank part has no program, so interrupts cannot revive it
    if (blank_hold) begin
      next_state = lpm_pkg::ST_SL4;
    end
  end

  // ==========================================================
  // state register, frozen until the vector check is done
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= lpm_pkg::ST_RUN;
    end else if (blank_checked) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // core enable, registered from the state
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_enable <= 1'h1;
    end else begin
      case (state)
        lpm_pkg::ST_SL0: cpu_enable <= 1'h0;
        lpm_pkg::ST_SL1: cpu_enable <= 1'h0;
        lpm_pkg::ST_SL2: cpu_enable <= 1'h0;
        lpm_pkg::ST_SL3: cpu_enable <= 1'h0;
        lpm_pkg::ST_SL4: cpu_enable <= 1'h0;
        default: cpu_enable <= 1'h1;
      endcase
    end
  end

  // ==========================================================
  // main clock enable
  always_ff @(posedge clk) begin
    if (srst) begin
      main_clk_en <= 1'h1;
    end else begin
      case (state)
        lpm_pkg::ST_SL0: main_clk_en <= 1'h0;
        lpm_pkg::ST_SL1: main_clk_en <= 1'h0;
        lpm_pkg::ST_SL2: main_clk_en <= 1'h0;
        lpm_pkg::ST_SL3: main_clk_en <= 1'h0;
        lpm_pkg::ST_SL4: main_clk_en <= 1'h0;
        default: main_clk_en <= 1'h1;
      endcase
    end
  end

  // ==========================================================
  // sub-main clock enable
  always_ff @(posedge clk) begin
    if (srst) begin
      sub_main_clock_en <= 1'h1;
    end else begin
      case (state)
        lpm_pkg::ST_SL0: sub_main_clock_en <= 1'h1;
        lpm_pkg::ST_SL1: sub_main_clock_en <= 1'h1;
        lpm_pkg::ST_SL2: sub_main_clock_en <= 1'h0;
        lpm_pkg::ST_SL3: sub_main_clock_en <= 1'h0;
        lpm_pkg::ST_SL4: sub_main_clock_en <= 1'h0;
        default: sub_main_clock_en <= 1'h1;
      endcase
    end
  end

  // ==========================================================
  // auxiliary clock enable, lost only at the deepest level
  always_ff @(posedge clk) begin
    if (srst) begin
      aux_clk_en <= 1'h1;
    end else begin
      case (state)
        lpm_pkg::ST_SL0: aux_clk_en <= 1'h1;
        lpm_pkg::ST_SL1: aux_clk_en <= 1'h1;
        lpm_pkg::ST_SL2: aux_clk_en <= 1'h1;
        lpm_pkg::ST_SL3: aux_clk_en <= 1'h1;
        lpm_pkg::ST_SL4: aux_clk_en <= 1'h0;
        default: aux_clk_en <= 1'h1;
      endcase
    end
  end

  // ==========================================================
  // dc generator; level 1 follows the source flag live, no latching
  always_ff @(posedge clk) begin
    if (srst) begin
      dc_gen_en <= 1'h1;
    end else begin
      case (state)
        lpm_pkg::ST_SL0: dc_gen_en <= 1'h1;
        lpm_pkg::ST_SL1: dc_gen_en <= digitally_controlled_osc_in_run;
        lpm_pkg::ST_SL2: dc_gen_en <= 1'h1;
        lpm_pkg::ST_SL3: dc_gen_en <= 1'h0;
        lpm_pkg::ST_SL4: dc_gen_en <= 1'h0;
        default: dc_gen_en <= 1'h1;
      endcase
    end
  end

  // ==========================================================
  // crystal oscillator enable
  always_ff @(posedge clk) begin
    if (srst) begin
      xtal_osc_en <= 1'h1;
    end else begin
      case (state)
        lpm_pkg::ST_SL0: xtal_osc_en <= 1'h1;
        lpm_pkg::ST_SL1: xtal_osc_en <= 1'h1;
        lpm_pkg::ST_SL2: xtal_osc_en <= 1'h1;
        lpm_pkg::ST_SL3: xtal_osc_en <= 1'h1;
        lpm_pkg::ST_SL4: xtal_osc_en <= 1'h0;
        default: xtal_osc_en <= 1'h1;
      endcase
    end
  end

  // ==========================================================
  // wake event, one cycle as the state returns to run
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_pulse <= 1'h0;
    end else begin
      wake_pulse <= blank_checked && (state != lpm_pkg::ST_RUN)
                    && (next_state == lpm_pkg::ST_RUN) && irq_sync;
    end
  end

  // ==========================================================
  // state as a mode code, one edge behind like the enables
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_state <= lpm_pkg::MODE_RUN;
    end else begin
      case (state)
        lpm_pkg::ST_SL0: mode_state <= lpm_pkg::MODE_SL0;
        lpm_pkg::ST_SL1: mode_state <= lpm_pkg::MODE_SL1;
        lpm_pkg::ST_SL2: mode_state <= lpm_pkg::MODE_SL2;
        lpm_pkg::ST_SL3: mode_state <= lpm_pkg::MODE_SL3;
        lpm_pkg::ST_SL4: mode_state <= lpm_pkg::MODE_SL4;
        default: mode_state <= lpm_pkg::MODE_RUN;
      endcase
    end
  end
endmodule

// File: dv/lpm_chk.sv
`timescale 1ns/1ps
// ==========================================================
// enable pattern {cpu,main,sub,aux,dcgen,xtal} against mode
module lpm_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic cpu_enable,
  input wire logic main_clk_en,
  input wire logic sub_main_clock_en,
  input wire logic aux_clk_en,
  input wire logic dc_gen_en,
  input wire logic digitally_controlled_osc_in_run,
  input wire logic xtal_osc_en,
  input wire logic wake_pulse,
  input wire logic [2:0] mode_state
);
  logic [5:0] en;
  assign en = {cpu_enable, main_clk_en, sub_main_clock_en, aux_clk_en, dc_gen_en, xtal_osc_en};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_up; en == 6'h3F && !wake_pulse; endsequence
  property p_run; mode_state == 3'h0 |-> en == 6'h3F; endproperty
  property p_sl0; mode_state == 3'h1 |-> en == 6'h0F; endproperty
  // dc gen shows the osc source flag as sampled one edge earlier
  property p_sl1;
    mode_state == 3'h2 |-> en == {4'h3, $past(digitally_controlled_osc_in_run), 1'h1};
  endproperty
  property p_sl2; mode_state == 3'h3 |-> en == 6'h07; endproperty
  property p_sl3; mode_state == 3'h4 |-> en == 6'h05; endproperty
  property p_sl4; mode_state == 3'h5 |-> en == 6'h00; endproperty
  property p_code; mode_state <= 3'h5; endproperty
  property p_wake; wake_pulse |=> s_up; endproperty
  a_run: assert property (p_run) else $error("run enables wrong");
  a_sl0: assert property (p_sl0) else $error("level 0 enables wrong");
  a_sl1: assert property (p_sl1) else $error("level 1 enables wrong");
  a_sl2: assert property (p_sl2) else $error("level 2 enables wrong");
  a_sl3: assert property (p_sl3) else $error("level 3 enables wrong");
  a_sl4: assert property (p_sl4) else $error("level 4 enables wrong");
  a_code: assert property (p_code) else $error("mode code out of range");
  a_wake: assert property (p_wake) else $error("wake did not restore run");
endmodule
bind low_power_mode_clock_gating lpm_chk chk (.clk, .srst, .cpu_enable, .main_clk_en,
  .sub_main_clock_en, .aux_clk_en, .dc_gen_en, .xtal_osc_en, .wake_pulse, .mode_state,
  .digitally_controlled_osc_in_run);

// File: dv/core_model.sv
`timescale 1ns/1ps
// ==========================================================
// core side: registered sleep code, run only once woken
module core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] sel,
  input wire logic irq,
  input wire logic wake,
  output logic [2:0] mode_req
);
  logic svc;
  always_ff @(posedge clk) begin
    svc <= !srst && (wake || (svc && irq));
    mode_req <= (srst || svc) ? lpm_pkg::MODE_RUN : sel;
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  // scenarios need about 110 cycles; the ceiling leaves wide margin
  localparam int TIMEOUT_CYCLES = 3000;
  logic clk, srst, irq, vld, osc_src, cpu, mck, sck, ack, dcg, xt, wk;
  logic [2:0] sel, mreq, mst;
  logic [15:0] vec;
  // expected {cpu,main,sub,aux,dcgen,xtal} per mode code; 6 and 7 act as run
  logic [5:0] tbl [8] = '{6'h3F, 6'h0F, 6'h0F, 6'h07, 6'h05, 6'h00, 6'h3F, 6'h3F};
  int n_errors, comparisons, cyc, n;
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  core_model core (.clk(clk), .srst(srst), .sel(sel), .irq(irq), .wake(wk), .mode_req(mreq));
  low_power_mode_clock_gating uut (.clk(clk), .srst(srst), .mode_req(mreq),
    .irq_pending(irq), .reset_vector(vec), .reset_vector_valid(vld),
    .digitally_controlled_osc_in_run(osc_src), .cpu_enable(cpu), .main_clk_en(mck),
    .sub_main_clock_en(sck), .aux_clk_en(ack), .dc_gen_en(dcg),
    .xtal_osc_en(xt), .wake_pulse(wk), .mode_state(mst));
  // ==========================================================
  // helpers
  task check(input string nm, input logic [5:0] got, input logic [5:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task go(input int k);
    repeat (k) @(negedge clk);
  endtask
  task do_reset(input logic [15:0] v);
    srst = 1'h1;
    vld = 1'h0;
    vec = v;
    go(6);
    srst = 1'h0;
    vld = 1'h1;
    go(4);
  endtask
  // ==========================================================
  // scenarios
  task sweep;
    logic [5:0] want;
    for (int c = 0; c < 8; c++) begin
      for (int d = 0; d < 2; d++) begin
        sel = c[2:0];
        osc_src = d[0];
        go(4);
        // level 1 drops the dc generator when the osc is not the run source
        want = (c == 2 && d == 0) ? (tbl[c] & 6'h3D) : tbl[c];
        check("enables", {cpu, mck, sck, ack, dcg, xt}, want);
        check("mode", {3'h0, mst}, (c > 5) ? 6'h00 : c[5:0]);
      end
    end
  endtask
  task wake;
    sel = lpm_pkg::MODE_SL3;
    go(4);
    irq = 1'h1;
    n = 0;
    while (wk !== 1'h1 && n < 8) begin
      go(1);
      n++;
    end
    check("wake", {5'h00, wk}, 6'h01);
    go(2);
    check("woken", {cpu, mck, sck, ack, dcg, xt}, 6'h3F);
    irq = 1'h0;
    go(6);
    check("resleep", {cpu, mck, sck, ack, dcg, xt}, 6'h05);
  endtask
  task blank;
    do_reset(16'hFFFF);
    sel = lpm_pkg::MODE_RUN;
    irq = 1'h1;
    go(8);
    check("blank", {cpu, mck, sck, ack, dcg, xt}, 6'h00);
    check("blank mode", {3'h0, mst}, 6'h05);
    irq = 1'h0;
  endtask
  // ==========================================================
  // run
  always @(posedge clk) begin
    cyc++;
    if (cyc == TIMEOUT_CYCLES) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    srst = 1'h1;
    irq = 1'h0;
    vld = 1'h0;
    osc_src = 1'h1;
    sel = 3'h0;
    vec = 16'h0000;
    do_reset(16'hC000);
    sweep;
    wake;
    blank;
    wrap_up;
  end
endmodule
